// >>> common/bdr_pkg.sv
// Shared constants and types for the baud detect and RSSI sample block
package bdr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_RATIO    = 6'h15;
    localparam logic [5:0] IDX_GOOD     = 6'h16;
    localparam logic [5:0] IDX_BAD      = 6'h17;
    localparam logic [5:0] IDX_SS       = 6'h18;
    localparam logic [5:0] IDX_CTRL     = 6'h1C;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h1D;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h1E;
    localparam logic [5:0] IDX_RSSI     = 6'h1F;

    // Field layout
    localparam int unsigned RATIO_W      = 4;
    localparam int unsigned TALLY_W      = 6;
    localparam int unsigned SS_W         = 6;
    localparam int unsigned RSSI_W       = 8;
    localparam int unsigned RATIO_FRAC_W = 2;
    localparam int unsigned CTRL_HALVE   = 0;
    localparam int unsigned CTRL_DIV_EN  = 1;
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_SAMPLE   = 0;
    localparam int unsigned IRQ_VALID    = 1;
    localparam int unsigned IRQ_SAT      = 2;

    // Reset values
    localparam logic [RATIO_W-1:0] RATIO_RST = 4'h0;
    localparam logic [SS_W-1:0]    SS_RST    = 6'h00;
    localparam logic [IRQ_W-1:0]   MASK_RST  = 3'h0;

    // Timing in input clock periods
    localparam logic [1:0] BAUD_CLKS_NORM = 2'h1;
    localparam logic [1:0] BAUD_CLKS_HALF = 2'h2;
    localparam logic [5:0] UNIT_CLKS_NORM = 6'h14;
    localparam logic [5:0] UNIT_CLKS_HALF = 6'h28;

    // Acceptable like-transition spacing in baud ticks
    localparam int unsigned GAP_W      = 6;
    localparam int unsigned GAP_LO_DEF = 16;
    localparam int unsigned GAP_HI_DEF = 24;

    typedef struct packed {
        logic               halve;
        logic               div_en;
        logic [RATIO_W-1:0] ratio;
        logic [SS_W-1:0]    ss;
    } bdr_cfg_s;

    typedef struct packed {
        logic [TALLY_W-1:0] good;
        logic [TALLY_W-1:0] bad;
    } bdr_tally_s;

    typedef enum logic {
        TMR_IDLE,
        TMR_RUN
    } bdr_tmr_e;
endpackage

// >>> test/bdr_core_tb_top.sv
// Testbench for the baud detect ratio, tallies and RSSI sample block
`timescale 1ns/100ps
`default_nettype none
module bdr_core_tb_top;
    logic        clk_i, rst_i, cyc, stb, we, ack, ant, rx, samp, valid, irq, go, done;
    logic [7:0]  adr, dwell, rssi, rval, h1, n1, h2, n2, lvl;
    logic [3:0]  sel;
    logic [31:0] dwr, drd;
    int          error_cnt, samples_checked, n;
    logic [3:0]  rt [4] = '{4'h3, 4'h4, 4'h0, 4'hF};

    bdr_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack),
        .rx_data_i(rx), .rssi_i(rssi), .antenna_switch_i(ant), .antenna_dwell_time_i(dwell[5:0]),
        .rssi_sample_o(samp), .rssi_value_o(rval), .signal_valid_o(valid), .irq_o(irq));
    bdr_radio_model radio (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .h1_i(h1), .n1_i(n1), .h2_i(h2),
        .n2_i(n2), .rssi_lvl_i(lvl), .rx_data_o(rx), .rssi_o(rssi), .done_o(done));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tmo(input string nm);
        error_cnt++;
        $display("[ERR] %s expected done seen timeout", nm);
        final_report();
    endtask

    // Classic single Wishbone cycle, held until ack
    task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        sel <= 4'hF;
        dwr <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) tmo("wb ack");
        r = drd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb(idx, 1'b1, d, r);
    endtask

    task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        wb(idx, 1'b0, 8'h00, r);
        check(nm, r, exp);
    endtask

    task automatic sw(input logic [7:0] d);
        @(posedge clk_i);
        ant   <= 1'b1;
        dwell <= d;
        @(posedge clk_i);
        ant   <= 1'b0;
    endtask

    task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] e);
        int k;
        @(posedge clk_i);
        go <= 1'b1;
        h1 <= a;
        n1 <= b;
        h2 <= c;
        n2 <= e;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 3000) tmo("rx run");
        repeat (10) @(posedge clk_i);
    endtask

    task automatic quiet();
        int k;
        k = 0;
        repeat (300) begin
            @(posedge clk_i);
            if (samp === 1'b1) k++;
        end
        check("no sample", k, 0);
    endtask

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        {cyc, stb, we, ant, go} = 5'h00;
        {adr, dwell, h1, n1, h2, n2} = 48'h0;
        sel = 4'h0;
        dwr = 32'h0;
        lvl = 8'hA5;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 8'h15; i <= 8'h1F; i++) rd_chk("reset value", i[5:0], 32'h0);
        wr(bdr_pkg::IDX_RATIO, 8'h0A);
        rd_chk("ratio rw", bdr_pkg::IDX_RATIO, 32'h0A);
        wr(bdr_pkg::IDX_GOOD, 8'h3F);
        rd_chk("good ro", bdr_pkg::IDX_GOOD, 32'h0);
        rd_chk("unmapped", 6'h20, 32'h0);
        // Good spacing 20 then bad spacing 8: 8 good, 10 bad
        sw(8'h05);
        run(8'h0A, 8'h0A, 8'h04, 8'h0A);
        rd_chk("good tally", bdr_pkg::IDX_GOOD, 32'h08);
        rd_chk("bad tally", bdr_pkg::IDX_BAD, 32'h0A);
        for (int i = 0; i < 4; i++) begin
            wr(bdr_pkg::IDX_RATIO, {4'h0, rt[i]});
            repeat (4) @(posedge clk_i);
            check("valid", {31'h0, valid}, {31'h0, (4 * 8 >= 10 * rt[i])});
        end
        wr(bdr_pkg::IDX_RATIO, 8'h00);
        sw(8'h05);
        repeat (4) @(posedge clk_i);
        rd_chk("good cleared", bdr_pkg::IDX_GOOD, 32'h0);
        rd_chk("bad cleared", bdr_pkg::IDX_BAD, 32'h0);
        check("valid cleared", {31'h0, valid}, 32'h0);
        wr(bdr_pkg::IDX_IRQ_STAT, 8'h07);
        wr(bdr_pkg::IDX_IRQ_MASK, 8'h04);
        run(8'h0A, 8'h46, 8'h04, 8'h00);
        rd_chk("good sat", bdr_pkg::IDX_GOOD, 32'h3F);
        rd_chk("bad none", bdr_pkg::IDX_BAD, 32'h0);
        check("irq sat", {31'h0, irq}, 32'h1);
        rd_chk("status", bdr_pkg::IDX_IRQ_STAT, 32'h06);
        wr(bdr_pkg::IDX_IRQ_STAT, 8'h07);
        rd_chk("status w1c", bdr_pkg::IDX_IRQ_STAT, 32'h0);
        check("irq clear", {31'h0, irq}, 32'h0);
        // Halved ticks: 40 clocks is 20 ticks, 20 clocks is 10 ticks
        wr(bdr_pkg::IDX_CTRL, 8'h01);
        sw(8'h05);
        run(8'h14, 8'h0A, 8'h0A, 8'h0A);
        rd_chk("good halved", bdr_pkg::IDX_GOOD, 32'h08);
        rd_chk("bad halved", bdr_pkg::IDX_BAD, 32'h0A);
        for (int h = 0; h < 2; h++) begin
            lvl <= h ? 8'h5A : 8'hA5;
            wr(bdr_pkg::IDX_CTRL, {6'h00, 1'b1, h[0]});
            // Sample start 3 units, well under dwell of 5 units
            wr(bdr_pkg::IDX_SS, 8'h03);
            wr(bdr_pkg::IDX_IRQ_MASK, {7'h00, h[0]});
            wr(bdr_pkg::IDX_IRQ_STAT, 8'h07);
            sw(8'h05);
            n = 0;
            while (samp !== 1'b1 && n < 400) begin
                @(posedge clk_i);
                n++;
            end
            if (n >= 400) tmo("rssi sample");
            check("sample time", {31'h0, (n >= 40 * (h + 1) - 1 && n <= 40 * (h + 1) + 3)}, 32'h1);
            @(posedge clk_i);
            check("rssi value", {24'h0, rval}, {24'h0, lvl});
            rd_chk("rssi reg", bdr_pkg::IDX_RSSI, {24'h0, lvl});
            rd_chk("sample status", bdr_pkg::IDX_IRQ_STAT, 32'h01);
            check("irq mask", {31'h0, irq}, h);
        end
        wr(bdr_pkg::IDX_SS, 8'h00);
        sw(8'h05);
        quiet();
        wr(bdr_pkg::IDX_CTRL, 8'h00);
        wr(bdr_pkg::IDX_SS, 8'h03);
        sw(8'h05);
        quiet();
        final_report();
    end
endmodule
`default_nettype wire

// >>> test/bdr_radio_model.sv
// Radio receive side model: rx data toggles in two spacing phases, steady RSSI
`timescale 1ns/100ps
`default_nettype none
module bdr_radio_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [7:0] h1_i,
    input  wire logic [7:0] n1_i,
    input  wire logic [7:0] h2_i,
    input  wire logic [7:0] n2_i,
    input  wire logic [7:0] rssi_lvl_i,
    output logic            rx_data_o,
    output logic      [7:0] rssi_o,
    output logic            done_o
);
    logic [7:0] left;
    logic [7:0] gap;
    logic [7:0] h1_r;
    logic [7:0] h2_r;
    logic [7:0] n2_r;

    // Toggle n1 times every h1 clocks, then n2 times every h2 clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_o <= 1'b0;
            left      <= 8'h00;
            gap       <= 8'h00;
        end else if (go_i) begin
            left <= n1_i + n2_i;
            gap  <= h1_i;
            h1_r <= h1_i;
            h2_r <= h2_i;
            n2_r <= n2_i;
        end else if (left != 8'h00) begin
            if (gap == 8'h01) begin
                rx_data_o <= ~rx_data_o;
                left      <= left - 8'h01;
                gap       <= (left - 8'h01 > n2_r) ? h1_r : h2_r;
            end else begin
                gap <= gap - 8'h01;
            end
        end
    end

    assign rssi_o = rssi_lvl_i;
    assign done_o = (left == 8'h00);
endmodule
`default_nettype wire

// >>> verilog/bdr_core.sv
// Baud detect ratio, transition tallies and RSSI sample timer
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module bdr_core #(
    parameter int unsigned GAP_LO = bdr_pkg::GAP_LO_DEF,
    parameter int unsigned GAP_HI = bdr_pkg::GAP_HI_DEF
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic                       rx_data_i,
    input  wire logic [bdr_pkg::RSSI_W-1:0] rssi_i,
    input  wire logic                       antenna_switch_i,
    input  wire logic [bdr_pkg::SS_W-1:0]   antenna_dwell_time_i,
    output logic                            rssi_sample_o,
    output logic      [bdr_pkg::RSSI_W-1:0] rssi_value_o,
    output logic                            signal_valid_o,
    output logic                            irq_o
);
    bdr_pkg::bdr_cfg_s                cfg_reg;
    bdr_pkg::bdr_tally_s              tally_reg;
    bdr_pkg::bdr_tally_s              tally_next;
    bdr_pkg::bdr_tmr_e                tmr_reg;
    logic [bdr_pkg::IRQ_W-1:0]        stat_reg;
    logic [bdr_pkg::IRQ_W-1:0]        mask_reg;
    logic [bdr_pkg::SS_W-1:0]         remain_reg;
    logic [bdr_pkg::RSSI_W-1:0]       rssi_s1_reg;
    logic [bdr_pkg::RSSI_W-1:0]       rssi_s2_reg;
    logic [bdr_pkg::RSSI_W-1:0]       rssi_val_reg;
    logic                             rx_s1_reg;
    logic                             rx_s2_reg;
    logic                             rx_d_reg;
    logic                             valid_reg;
    logic                             sample_reg;
    logic                             ack_reg;
    logic [31:0]                      dat_reg;

    function automatic logic [bdr_pkg::TALLY_W-1:0] sat_inc(input logic [bdr_pkg::TALLY_W-1:0] v,
                                                            input logic inc);
        sat_inc = (inc && v != '1) ? v + bdr_pkg::TALLY_W'(1) : v;
    endfunction

    // Bus decode
    wire       [5:0]  idx;
    wire              req;
    wire              wr_acc;
    wire              wr_b0;
    logic      [31:0] rd_mux;
    assign idx    = wb_adr_i[7:2];
    assign req    = wb_cyc_i && wb_stb_i;
    assign wr_acc = req && ack_reg && wb_we_i;
    assign wr_b0  = wr_acc && wb_sel_i[0];

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            bdr_pkg::IDX_RATIO:    rd_mux[bdr_pkg::RATIO_W-1:0] = cfg_reg.ratio;
            bdr_pkg::IDX_GOOD:     rd_mux[bdr_pkg::TALLY_W-1:0] = tally_reg.good;
            bdr_pkg::IDX_BAD:      rd_mux[bdr_pkg::TALLY_W-1:0] = tally_reg.bad;
            bdr_pkg::IDX_SS:       rd_mux[bdr_pkg::SS_W-1:0] = cfg_reg.ss;
            bdr_pkg::IDX_CTRL: begin
                rd_mux[bdr_pkg::CTRL_HALVE]  = cfg_reg.halve;
                rd_mux[bdr_pkg::CTRL_DIV_EN] = cfg_reg.div_en;
            end
            bdr_pkg::IDX_IRQ_STAT: rd_mux[bdr_pkg::IRQ_W-1:0] = stat_reg;
            bdr_pkg::IDX_IRQ_MASK: rd_mux[bdr_pkg::IRQ_W-1:0] = mask_reg;
            bdr_pkg::IDX_RSSI:     rd_mux[bdr_pkg::RSSI_W-1:0] = rssi_val_reg;
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && !ack_reg;
            dat_reg <= (req && !ack_reg) ? rd_mux : dat_reg;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg.halve  <= 1'b0;
            cfg_reg.div_en <= 1'b0;
            cfg_reg.ratio  <= bdr_pkg::RATIO_RST;
            cfg_reg.ss     <= bdr_pkg::SS_RST;
            mask_reg       <= bdr_pkg::MASK_RST;
        end else if (wr_b0) begin
            case (idx)
                bdr_pkg::IDX_RATIO:    cfg_reg.ratio <= wb_dat_i[bdr_pkg::RATIO_W-1:0];
                bdr_pkg::IDX_SS:       cfg_reg.ss <= wb_dat_i[bdr_pkg::SS_W-1:0];
                bdr_pkg::IDX_CTRL: begin
                    cfg_reg.halve  <= wb_dat_i[bdr_pkg::CTRL_HALVE];
                    cfg_reg.div_en <= wb_dat_i[bdr_pkg::CTRL_DIV_EN];
                end
                bdr_pkg::IDX_IRQ_MASK: mask_reg <= wb_dat_i[bdr_pkg::IRQ_W-1:0];
                default:               mask_reg <= mask_reg;
            endcase
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_reg   <= 1'b0;
            rx_s2_reg   <= 1'b0;
            rx_d_reg    <= 1'b0;
            rssi_s1_reg <= '0;
            rssi_s2_reg <= '0;
        end else begin
            rx_s1_reg   <= rx_data_i;
            rx_s2_reg   <= rx_s1_reg;
            rx_d_reg    <= rx_s2_reg;
            rssi_s1_reg <= rssi_i;
            rssi_s2_reg <= rssi_s1_reg;
        end
    end

    wire       baud_tick;
    wire [1:0] baud_period;
    assign baud_period = cfg_reg.halve ? bdr_pkg::BAUD_CLKS_HALF : bdr_pkg::BAUD_CLKS_NORM;
    bdr_tick_gen #(.CNT_W(2)) u_baud_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (1'b0),
        .period_i  (baud_period),
        .tick_o    (baud_tick)
    );

    wire rise_edge;
    wire fall_edge;
    wire good_r;
    wire bad_r;
    wire good_f;
    wire bad_f;
    assign rise_edge = rx_s2_reg && !rx_d_reg;
    assign fall_edge = !rx_s2_reg && rx_d_reg;

    bdr_edge_check #(.CNT_W(bdr_pkg::GAP_W), .LIMIT_LO(GAP_LO), .LIMIT_HI(GAP_HI)) u_rise_chk (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (antenna_switch_i),
        .tick_i  (baud_tick),
        .edge_i  (rise_edge),
        .good_o  (good_r),
        .bad_o   (bad_r)
    );
    bdr_edge_check #(.CNT_W(bdr_pkg::GAP_W), .LIMIT_LO(GAP_LO), .LIMIT_HI(GAP_HI)) u_fall_chk (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (antenna_switch_i),
        .tick_i  (baud_tick),
        .edge_i  (fall_edge),
        .good_o  (good_f),
        .bad_o   (bad_f)
    );

    always_comb begin
        tally_next.good = sat_inc(tally_reg.good, good_r || good_f);
        tally_next.bad  = sat_inc(tally_reg.bad, bad_r || bad_f);
        if (antenna_switch_i) begin
            tally_next = '0;
        end
    end

    // good x 4 against ratio x bad
    wire [9:0] good_scaled;
    wire [9:0] bad_scaled;
    wire       ratio_met;
    assign good_scaled = {2'h0, tally_reg.good, bdr_pkg::RATIO_FRAC_W'(0)};
    assign bad_scaled  = {6'h00, cfg_reg.ratio} * {4'h0, tally_reg.bad};
    assign ratio_met   = (tally_reg.good != '0) && (good_scaled >= bad_scaled);

    wire       unit_tick;
    wire [5:0] unit_period;
    assign unit_period = cfg_reg.halve ? bdr_pkg::UNIT_CLKS_HALF : bdr_pkg::UNIT_CLKS_NORM;
    bdr_tick_gen #(.CNT_W(6)) u_unit_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (antenna_switch_i),
        .period_i  (unit_period),
        .tick_o    (unit_tick)
    );

    // sample when remaining dwell equals sample start
    wire                       step;
    wire [bdr_pkg::SS_W-1:0]   remain_dec;
    wire                       fire;
    assign step       = (tmr_reg == bdr_pkg::TMR_RUN) && unit_tick && remain_reg != '0;
    assign remain_dec = remain_reg - bdr_pkg::SS_W'(1);
    assign fire       = step && cfg_reg.div_en && cfg_reg.ss != '0 && remain_dec == cfg_reg.ss;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_reg    <= bdr_pkg::TMR_IDLE;
            remain_reg <= '0;
        end else begin
            case (tmr_reg)
                bdr_pkg::TMR_IDLE: begin
                    if (antenna_switch_i) begin
                        tmr_reg    <= bdr_pkg::TMR_RUN;
                        remain_reg <= antenna_dwell_time_i;
                    end
                end
                bdr_pkg::TMR_RUN: begin
                    if (antenna_switch_i) begin
                        remain_reg <= antenna_dwell_time_i;
                    end else if (step) begin
                        remain_reg <= remain_dec;
                        tmr_reg    <= (remain_dec == '0) ? bdr_pkg::TMR_IDLE : bdr_pkg::TMR_RUN;
                    end
                end
                default: tmr_reg <= bdr_pkg::TMR_IDLE;
            endcase
        end
    end

    // Interrupt events
    wire [bdr_pkg::IRQ_W-1:0] ev;
    wire [bdr_pkg::IRQ_W-1:0] clr;
    assign ev[bdr_pkg::IRQ_SAMPLE] = fire;
    assign ev[bdr_pkg::IRQ_VALID]  = ratio_met && !valid_reg;
    assign ev[bdr_pkg::IRQ_SAT]    = (tally_next.good == '1 && tally_reg.good != '1)
                                   || (tally_next.bad == '1 && tally_reg.bad != '1);
    assign clr = (wr_b0 && idx == bdr_pkg::IDX_IRQ_STAT) ? wb_dat_i[bdr_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tally_reg    <= '0;
            valid_reg    <= 1'b0;
            sample_reg   <= 1'b0;
            rssi_val_reg <= '0;
            stat_reg     <= '0;
        end else begin
            tally_reg    <= tally_next;
            valid_reg    <= ratio_met;
            sample_reg   <= fire;
            rssi_val_reg <= fire ? rssi_s2_reg : rssi_val_reg;
            stat_reg     <= (stat_reg & ~clr) | ev;
        end
    end

    assign rssi_sample_o  = sample_reg;
    assign rssi_value_o   = rssi_val_reg;
    assign signal_valid_o = valid_reg;
    assign irq_o          = |(stat_reg & mask_reg);

    // Checks
    sequence s_ss_write;
        wr_b0 && idx == bdr_pkg::IDX_SS;
    endsequence

    sequence s_read_good;
        req && !ack_reg && !wb_we_i && idx == bdr_pkg::IDX_GOOD;
    endsequence

    sequence s_read_bad;
        req && !ack_reg && !wb_we_i && idx == bdr_pkg::IDX_BAD;
    endsequence

    logic [6:0] gap_cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || antenna_switch_i || unit_tick) begin
            gap_cnt_reg <= '0;
        end else if (cfg_reg.halve != $past(cfg_reg.halve)) begin
            gap_cnt_reg <= '1;
        end else if (gap_cnt_reg != '1) begin
            gap_cnt_reg <= gap_cnt_reg + 7'h01;
        end
    end

    a_valid_ratio_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        signal_valid_o |-> ($past(good_scaled) >= $past(bad_scaled) && $past(tally_reg.good) != '0))
        else $error("Valid shown without meeting ratio");
    a_good_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_good |=> wb_ack_o && wb_dat_o == {26'h0, $past(tally_reg.good)})
        else $error("Good tally read wrong");
    a_bad_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_read_bad |=> wb_ack_o && wb_dat_o == {26'h0, $past(tally_reg.bad)})
        else $error("Bad tally read wrong");
    a_switch_clears_tally: assert property (@(posedge clk_i) disable iff (rst_i)
        antenna_switch_i |=> tally_reg.good == '0 && tally_reg.bad == '0)
        else $error("Tally not cleared on antenna change");
    a_zero_no_sample: assert property (@(posedge clk_i) disable iff (rst_i)
        (cfg_reg.ss == '0 && $past(cfg_reg.ss) == '0) |-> !rssi_sample_o)
        else $error("Sample taken with zero start");
    a_sample_at_start: assert property (@(posedge clk_i) disable iff (rst_i)
        rssi_sample_o |-> remain_reg == $past(cfg_reg.ss) && rssi_value_o == $past(rssi_s2_reg))
        else $error("Sample at wrong time");
    a_unit_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        (unit_tick && $past(unit_tick) == 1'b0 && $stable(cfg_reg.halve) && gap_cnt_reg != '1 && gap_cnt_reg != '0)
        |-> gap_cnt_reg == 7'(unit_period) - 7'h01)
        else $error("Sample unit spacing wrong");
    a_baud_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        (baud_tick && cfg_reg.halve && $past(cfg_reg.halve)) |=> (!baud_tick || !cfg_reg.halve))
        else $error("Halved baud tick too fast");
    a_tally_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
        (tally_reg.good == '1 && !antenna_switch_i) |=> tally_reg.good == '1)
        else $error("Good tally wrapped");
    a_ss_store: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ss_write |=> cfg_reg.ss == $past(wb_dat_i[bdr_pkg::SS_W-1:0]))
        else $error("Sample start not stored");
endmodule
`default_nettype wire

// >>> verilog/bdr_edge_check.sv
// Spacing test between like transitions
`timescale 1ns/100ps
`default_nettype none
module bdr_edge_check #(
    parameter int unsigned CNT_W    = 6,
    parameter int unsigned LIMIT_LO = 16,
    parameter int unsigned LIMIT_HI = 24
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic clear_i,
    input  wire logic tick_i,
    input  wire logic edge_i,
    output logic      good_o,
    output logic      bad_o
);
    logic [CNT_W-1:0] gap_reg;
    logic             seen_reg;
    wire              in_range;

    if (LIMIT_LO > LIMIT_HI || LIMIT_HI >= (1 << CNT_W)) begin : g_bad_limits
        $error("Bad gap limits");
    end

    assign in_range = (gap_reg >= CNT_W'(LIMIT_LO)) && (gap_reg <= CNT_W'(LIMIT_HI));
    assign good_o   = edge_i && seen_reg && in_range;
    assign bad_o    = edge_i && seen_reg && !in_range;

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            gap_reg  <= '0;
            seen_reg <= 1'b0;
        end else if (edge_i) begin
            gap_reg  <= '0;
            seen_reg <= 1'b1;
        end else if (tick_i && gap_reg != '1) begin
            gap_reg <= gap_reg + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// >>> verilog/bdr_tick_gen.sv
// Programmable tick divider
`timescale 1ns/100ps
`default_nettype none
module bdr_tick_gen #(
    parameter int unsigned CNT_W = 6
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             restart_i,
    input  wire logic [CNT_W-1:0] period_i,
    output logic                  tick_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire              at_end;

    if (CNT_W < 1) begin : g_bad_cnt_w
        $error("CNT_W must be at least 1");
    end

    assign at_end   = cnt_reg >= (period_i - CNT_W'(1));
    assign tick_o   = !restart_i && at_end;
    assign cnt_next = (restart_i || at_end) ? '0 : cnt_reg + CNT_W'(1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire
